// file: verilog/exec_unit.sv
// instruction execution unit: irq on/off, paged and computed jumps,
// increment, increment-skip-zero and software trap, driven over Wishbone
// assumes a classic Wishbone master on MCLK; one instruction in flight
// How it works
// - irq-off clears the global irq enable, one cycle.
// - irq-on sets the global irq enable.
// - paged jump loads 9-bit address into pc[8:0], buffer bits 2:1 into pc[10:9].
// - computed jump loads pc from all three table pointer bits and accumulator, two cycles.
// - increment adds one to a register, dest bit picks target, updates zero.
// - trap pushes pc plus one, then loads pc with one, three cycles.
// - increment-skip stores the sum to accumulator or register by dest bit.
// - increment-skip with zero result runs a nop slot, taking two cycles.
`default_nettype none
module exec_unit #(
    parameter int REGS = 128,
    parameter int STACK_DEPTH = 8
) (
    input wire logic MCLK,
    input wire logic RST,
    input wire logic CYC_I,
    input wire logic STB_I,
    input wire logic WE_I,
    input wire logic [7:0] ADR_I,
    input wire logic [3:0] SEL_I,
    input wire logic [31:0] DAT_I,
    output logic [31:0] DAT_O,
    output logic ACK_O,
    output logic IRQ_ENABLE
);
    typedef enum logic {IDLE, EXEC} state_t;

    state_t state;
    exec_pkg::opcode_t op;
    logic dest;
    logic [exec_pkg::REG_ADR_W-1:0] reg_index;
    logic [exec_pkg::JUMP_ADR_W-1:0] jump_adr;
    logic [1:0] cnt;
    logic [7:0] accumulator;
    logic [10:0] pc;
    logic [2:0] pc_high_buffer;
    logic [2:0] table_high_pointer;
    logic global_irq_enable;
    logic zero;
    logic carry;
    logic [exec_pkg::REG_ADR_W-1:0] reg_select;
    logic [7:0] file [REGS];
    logic [10:0] stack_top;
    logic [2:0] stack_level;

    // bus decode and byte-lane merge
    wire bus_req = CYC_I && STB_I;
    wire bus_commit = bus_req && ACK_O;
    wire busy = (state == EXEC);
    wire wr_ok = bus_commit && WE_I && !busy;
    wire [31:0] lane_mask = {{8{SEL_I[3]}}, {8{SEL_I[2]}}, {8{SEL_I[1]}}, {8{SEL_I[0]}}};
    wire hit_cmd = (ADR_I == exec_pkg::OFF_COMMAND);
    wire hit_acc = (ADR_I == exec_pkg::OFF_ACCUMULATOR);
    wire hit_pc = (ADR_I == exec_pkg::OFF_PROGRAM_COUNTER);
    wire hit_phb = (ADR_I == exec_pkg::OFF_PC_HIGH_BUFFER);
    wire hit_thp = (ADR_I == exec_pkg::OFF_TABLE_HIGH_POINTER);
    wire hit_st = (ADR_I == exec_pkg::OFF_STATUS);
    wire hit_sel = (ADR_I == exec_pkg::OFF_REG_SELECT);
    wire hit_dat = (ADR_I == exec_pkg::OFF_REG_DATA);
    wire hit_stk = (ADR_I == exec_pkg::OFF_STACK_TOP);

    wire [31:0] status_word = {21'h00_0000, stack_level, 4'h0, busy, carry, zero,
        global_irq_enable};
    wire [31:0] read_word =
        hit_cmd ? {7'h00, jump_adr, 1'b0, reg_index, 4'h0, dest, op} :
        hit_acc ? {24'h00_0000, accumulator} :
        hit_pc ? {21'h00_0000, pc} :
        hit_phb ? {29'h0000_0000, pc_high_buffer} :
        hit_thp ? {29'h0000_0000, table_high_pointer} :
        hit_st ? status_word :
        hit_sel ? {25'h000_0000, reg_select} :
        hit_dat ? {24'h00_0000, file[reg_select]} :
        hit_stk ? {21'h00_0000, stack_top} : 32'h0000_0000;
    wire [31:0] merged = (read_word & ~lane_mask) | (DAT_I & lane_mask);

    // execution datapath
    wire [7:0] operand = file[reg_index];
    wire [7:0] sum = 8'(operand + 8'h01);
    wire sum_zero = (sum == 8'h00);
    wire first = busy && (cnt == 2'h0);
    wire [10:0] pc_next = 11'(pc + 11'h001);
    wire is_increment_op = (op == exec_pkg::INCREMENT_OP) || (op == exec_pkg::INCREMENT_SKIP_ZERO_OP);
    wire is_skip = (op == exec_pkg::INCREMENT_SKIP_ZERO_OP);
    // skip is decided from the first-cycle sum, before the register changes
    wire last_cycle =
        (op == exec_pkg::TRAP_OP) ? (cnt == exec_pkg::LAST_TRAP) :
        (op == exec_pkg::PAGED_JUMP_OP || op == exec_pkg::COMPUTED_JUMP_OP) ?
            (cnt == exec_pkg::LAST_JUMP) :
        is_skip ? (cnt == exec_pkg::LAST_SKIP || !sum_zero) : 1'b1;
    wire do_push = first && (op == exec_pkg::TRAP_OP);
    wire file_wr_exec = first && is_increment_op && dest;
    wire file_wr_bus = wr_ok && hit_dat;

    return_stack #(
        .WIDTH(exec_pkg::PC_W),
        .DEPTH(STACK_DEPTH),
        .PTR_W(3)
    ) u_stack (
        .clk(MCLK),
        .rst(RST),
        .push(do_push),
        .push_data(pc_next),
        .top(stack_top),
        .level(stack_level)
    );

    // wishbone answer: one wait state, ack for one cycle
    always_ff @(posedge MCLK) begin
        if (RST) begin
            ACK_O <= 1'b0;
            DAT_O <= 32'h0000_0000;
        end else begin
            ACK_O <= bus_req && !ACK_O;
            DAT_O <= (bus_req && !ACK_O && !WE_I) ? read_word : 32'h0000_0000;
        end
    end

    // register file has no reset; software initialises it
    always_ff @(posedge MCLK) begin
        if (file_wr_exec) begin
            file[reg_index] <= sum;
        end else if (file_wr_bus) begin
            file[reg_select] <= merged[7:0];
        end
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            state <= IDLE;
            cnt <= 2'h0;
        end else if (wr_ok && hit_cmd) begin
            state <= EXEC;
            cnt <= 2'h0;
        end else if (busy) begin
            state <= last_cycle ? IDLE : EXEC;
            cnt <= 2'(cnt + 2'h1);
        end
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            op <= exec_pkg::IRQ_OFF_OP;
            dest <= 1'b0;
            reg_index <= '0;
            jump_adr <= '0;
            reg_select <= '0;
            pc_high_buffer <= exec_pkg::RST_HIGH;
            table_high_pointer <= exec_pkg::RST_HIGH;
        end else if (wr_ok) begin
            if (hit_cmd) begin
                op <= exec_pkg::opcode_t'(merged[exec_pkg::CMD_OP_LSB +: 3]);
                dest <= merged[exec_pkg::CMD_DEST_BIT];
                reg_index <= merged[exec_pkg::CMD_REG_LSB +: exec_pkg::REG_ADR_W];
                jump_adr <= merged[exec_pkg::CMD_ADR_LSB +: exec_pkg::JUMP_ADR_W];
            end
            if (hit_sel) begin
                reg_select <= merged[exec_pkg::REG_ADR_W-1:0];
            end
            if (hit_phb) begin
                pc_high_buffer <= merged[2:0];
            end
            if (hit_thp) begin
                table_high_pointer <= merged[2:0];
            end
        end
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            accumulator <= exec_pkg::RST_ACCUMULATOR;
        end else if (first && is_increment_op && !dest) begin
            accumulator <= sum;
        end else if (wr_ok && hit_acc) begin
            accumulator <= merged[7:0];
        end
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            zero <= 1'b0;
            carry <= 1'b0;
        end else if (first && is_increment_op) begin
            zero <= sum_zero;
        end else if (wr_ok && hit_st) begin
            zero <= merged[exec_pkg::ST_ZERO_BIT];
            carry <= merged[exec_pkg::ST_CARRY_BIT];
        end
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            global_irq_enable <= exec_pkg::RST_IRQ_EN;
        end else if (first && op == exec_pkg::IRQ_OFF_OP) begin
            global_irq_enable <= 1'b0;
        end else if (first && op == exec_pkg::IRQ_ON_OP) begin
            global_irq_enable <= 1'b1;
        end else if (wr_ok && hit_st) begin
            global_irq_enable <= merged[exec_pkg::ST_IRQ_EN_BIT];
        end
    end

    assign IRQ_ENABLE = global_irq_enable;

    // pc: jumps and the trap load at their last cycle, others step by one each busy cycle
    always_ff @(posedge MCLK) begin
        if (RST) begin
            pc <= exec_pkg::RST_PC;
        end else if (busy) begin
            case (op)
                exec_pkg::PAGED_JUMP_OP: begin
                    if (last_cycle) pc <= {pc_high_buffer[2:1], jump_adr};
                end
                exec_pkg::COMPUTED_JUMP_OP: begin
                    if (last_cycle) pc <= {table_high_pointer, accumulator};
                end
                exec_pkg::TRAP_OP: begin
                    if (last_cycle) pc <= exec_pkg::TRAP_VECTOR;
                end
                default: begin
                    pc <= pc_next;
                end
            endcase
        end else if (wr_ok && hit_pc) begin
            pc <= merged[10:0];
        end
    end

    // checks
    property p_irq_off;
        @(posedge MCLK) disable iff (RST)
        (first && op == exec_pkg::IRQ_OFF_OP) |=> !global_irq_enable && !busy;
    endproperty
    a_irq_off: assert property (p_irq_off) else $error("irq off failed");

    property p_irq_on;
        @(posedge MCLK) disable iff (RST)
        (first && op == exec_pkg::IRQ_ON_OP) |=> global_irq_enable && IRQ_ENABLE;
    endproperty
    a_irq_on: assert property (p_irq_on) else $error("irq on failed");

    property p_paged;
        @(posedge MCLK) disable iff (RST)
        (first && op == exec_pkg::PAGED_JUMP_OP) |=> busy ##1
            (!busy && pc == {$past(pc_high_buffer[2:1], 2), $past(jump_adr, 2)});
    endproperty
    a_paged: assert property (p_paged) else $error("paged jump wrong");

    property p_computed;
        @(posedge MCLK) disable iff (RST)
        (first && op == exec_pkg::COMPUTED_JUMP_OP) |=> busy ##1
            (!busy && pc == {$past(table_high_pointer, 2), $past(accumulator, 2)});
    endproperty
    a_computed: assert property (p_computed) else $error("computed jump wrong");

    property p_increment_op_acc;
        @(posedge MCLK) disable iff (RST)
        (first && op == exec_pkg::INCREMENT_OP && !dest) |=>
            accumulator == 8'($past(operand) + 8'h01) && zero == (accumulator == 8'h00)
            && !busy;
    endproperty
    a_increment_op_acc: assert property (p_increment_op_acc) else $error("increment wrong");

    property p_trap;
        @(posedge MCLK) disable iff (RST)
        (first && op == exec_pkg::TRAP_OP) |=> stack_top == 11'($past(pc) + 11'h001)
            ##0 busy[*2] ##1 (!busy && pc == exec_pkg::TRAP_VECTOR);
    endproperty
    a_trap: assert property (p_trap) else $error("trap wrong");

    property p_skip_dest;
        @(posedge MCLK) disable iff (RST)
        (first && is_skip && dest) |=> file[reg_index] == 8'($past(operand) + 8'h01);
    endproperty
    a_skip_dest: assert property (p_skip_dest) else $error("skip store wrong");

    property p_skip_slot;
        @(posedge MCLK) disable iff (RST)
        (first && is_skip && sum_zero) |=> busy ##1
            (!busy && pc == 11'($past(pc, 2) + 11'h002));
    endproperty
    a_skip_slot: assert property (p_skip_slot) else $error("skip slot wrong");

    property p_flags_kept;
        @(posedge MCLK) disable iff (RST)
        (busy && !is_increment_op) |=> $stable(zero) && $stable(carry);
    endproperty
    a_flags_kept: assert property (p_flags_kept) else $error("flags changed");

    c_trap: cover property (@(posedge MCLK) disable iff (RST)
        first && op == exec_pkg::TRAP_OP);
    c_skip: cover property (@(posedge MCLK) disable iff (RST)
        first && is_skip && sum_zero);
    c_paged: cover property (@(posedge MCLK) disable iff (RST)
        first && op == exec_pkg::PAGED_JUMP_OP);
endmodule // exec_unit
`default_nettype wire

// file: verilog/exec_pkg.sv
// constants shared by the instruction execution unit and its testbench
// assumes a 32-bit classic Wishbone slave port with word-aligned byte addresses
`default_nettype none
package exec_pkg;
    // register byte offsets
    localparam logic [7:0] OFF_COMMAND = 8'h00;
    localparam logic [7:0] OFF_ACCUMULATOR = 8'h04;
    localparam logic [7:0] OFF_PROGRAM_COUNTER = 8'h08;
    localparam logic [7:0] OFF_PC_HIGH_BUFFER = 8'h0C;
    localparam logic [7:0] OFF_TABLE_HIGH_POINTER = 8'h10;
    localparam logic [7:0] OFF_STATUS = 8'h14;
    localparam logic [7:0] OFF_REG_SELECT = 8'h18;
    localparam logic [7:0] OFF_REG_DATA = 8'h1C;
    localparam logic [7:0] OFF_STACK_TOP = 8'h20;
    // command word fields
    localparam int CMD_OP_LSB = 0;
    localparam int CMD_DEST_BIT = 3;
    localparam int CMD_REG_LSB = 8;
    localparam int CMD_ADR_LSB = 16;
    // status word fields
    localparam int ST_IRQ_EN_BIT = 0;
    localparam int ST_ZERO_BIT = 1;
    localparam int ST_CARRY_BIT = 2;
    localparam int ST_BUSY_BIT = 3;
    localparam int ST_LEVEL_LSB = 8;
    // widths
    localparam int PC_W = 11;
    localparam int REG_ADR_W = 7;
    localparam int JUMP_ADR_W = 9;
    // reset values
    localparam logic [7:0] RST_ACCUMULATOR = 8'h00;
    localparam logic [10:0] RST_PC = 11'h000;
    localparam logic [2:0] RST_HIGH = 3'h0;
    localparam logic RST_IRQ_EN = 1'b0;
    // trap vector
    localparam logic [10:0] TRAP_VECTOR = 11'h001;
    // cycle counts of the multi-cycle instructions, last cycle index
    localparam logic [1:0] LAST_JUMP = 2'h1;
    localparam logic [1:0] LAST_TRAP = 2'h2;
    localparam logic [1:0] LAST_SKIP = 2'h1;
    typedef enum logic [2:0] {
        IRQ_OFF_OP = 3'h0,
        IRQ_ON_OP = 3'h1,
        PAGED_JUMP_OP = 3'h2,
        COMPUTED_JUMP_OP = 3'h3,
        INCREMENT_OP = 3'h4,
        INCREMENT_SKIP_ZERO_OP = 3'h5,
        TRAP_OP = 3'h6,
        SPARE_OP = 3'h7
    } opcode_t;
endpackage
`default_nettype wire

// file: verilog/return_stack.sv
// circular return-address stack kept in flip-flops
// assumes one push per cycle at most; overflow overwrites the oldest entry
`default_nettype none
module return_stack #(
    parameter int WIDTH = 11,
    parameter int DEPTH = 8,
    parameter int PTR_W = 3
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic push,
    input wire logic [WIDTH-1:0] push_data,
    output logic [WIDTH-1:0] top,
    output logic [PTR_W-1:0] level
);
    logic [WIDTH-1:0] entry [DEPTH];
    logic [PTR_W-1:0] ptr;
    wire [PTR_W-1:0] top_index = PTR_W'(ptr - 1'b1);

    always_ff @(posedge clk) begin
        if (rst) begin
            ptr <= '0;
        end else if (push) begin
            ptr <= PTR_W'(ptr + 1'b1);
        end
    end

    genvar i;
    generate
        for (i = 0; i < DEPTH; i++) begin : g_entry
            always_ff @(posedge clk) begin
                if (rst) begin
                    entry[i] <= '0;
                end else if (push && ptr == PTR_W'(i)) begin
                    entry[i] <= push_data;
                end
            end
        end
    endgenerate

    assign top = entry[top_index];
    assign level = ptr;
endmodule // return_stack
`default_nettype wire

// file: test/test_exec_unit.sv
// self-checking bench for the instruction execution unit
// assumes the unit answers every Wishbone request after one wait cycle
`default_nettype none
module test_exec_unit;
    timeunit 1ns;
    timeprecision 1ps;
    logic MCLK;
    logic RST;
    logic CYC_I;
    logic STB_I;
    logic WE_I;
    logic [7:0] ADR_I;
    logic [3:0] SEL_I;
    logic [31:0] DAT_I;
    logic [31:0] DAT_O;
    logic ACK_O;
    logic IRQ_ENABLE;
    logic [31:0] rd;
    logic [31:0] pc0;
    int n_fail;
    int cmp_count;

    exec_unit #(.REGS(128), .STACK_DEPTH(8)) DUT (
        .MCLK(MCLK),
        .RST(RST),
        .CYC_I(CYC_I),
        .STB_I(STB_I),
        .WE_I(WE_I),
        .ADR_I(ADR_I),
        .SEL_I(SEL_I),
        .DAT_I(DAT_I),
        .DAT_O(DAT_O),
        .ACK_O(ACK_O),
        .IRQ_ENABLE(IRQ_ENABLE)
    );

    initial begin
        MCLK = 1'b0;
        forever #5 MCLK = ~MCLK;
    end

    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // one classic cycle; the request is held until ack is sampled high
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] din,
                      input logic [3:0] sel, output logic [31:0] dout);
        int n;
        @(posedge MCLK);
        CYC_I <= 1'b1;
        STB_I <= 1'b1;
        WE_I <= we;
        ADR_I <= adr;
        SEL_I <= sel;
        DAT_I <= din;
        n = 0;
        do begin
            @(posedge MCLK);
            n++;
        end while (ACK_O !== 1'b1 && n < 50);
        if (n >= 50) begin
            n_fail++;
            $display("wrong value at %0t: no ack", $time);
        end
        dout = DAT_O;
        CYC_I <= 1'b0;
        STB_I <= 1'b0;
        WE_I <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] adr, input logic [31:0] d);
        logic [31:0] dummy;
        wb(1'b1, adr, d, 4'hF, dummy);
    endtask

    task automatic rdr(input logic [7:0] adr, output logic [31:0] d);
        wb(1'b0, adr, 32'h0000_0000, 4'hF, d);
    endtask

    // launch one instruction and wait, bounded, until busy clears
    task automatic exec(input logic [2:0] op, input logic dest, input logic [6:0] r,
                        input logic [8:0] adr);
        logic [31:0] c;
        logic [31:0] s;
        int n;
        c = 32'h0000_0000;
        c[exec_pkg::CMD_OP_LSB +: 3] = op;
        c[exec_pkg::CMD_DEST_BIT] = dest;
        c[exec_pkg::CMD_REG_LSB +: 7] = r;
        c[exec_pkg::CMD_ADR_LSB +: 9] = adr;
        wr(exec_pkg::OFF_COMMAND, c);
        n = 0;
        do begin
            rdr(exec_pkg::OFF_STATUS, s);
            n++;
        end while (s[exec_pkg::ST_BUSY_BIT] !== 1'b0 && n < 20);
        check({31'h0, s[exec_pkg::ST_BUSY_BIT]}, 32'h0000_0000);
    endtask

    initial begin
        #200000;
        n_fail++;
        end_sim();
    end

    initial begin
        n_fail = 0;
        cmp_count = 0;
        RST = 1'b1;
        CYC_I = 1'b0;
        STB_I = 1'b0;
        WE_I = 1'b0;
        ADR_I = 8'h00;
        SEL_I = 4'hF;
        DAT_I = 32'h0000_0000;
        repeat (10) @(posedge MCLK);
        RST <= 1'b0;
        rdr(exec_pkg::OFF_STATUS, rd);
        check(rd, 32'h0000_0000);
        rdr(exec_pkg::OFF_PROGRAM_COUNTER, rd);
        check(rd, 32'h0000_0000);
        // unmapped place: write ignored, read zero
        wr(8'h3C, 32'hFFFF_FFFF);
        rdr(8'h3C, rd);
        check(rd, 32'h0000_0000);
        exec(exec_pkg::IRQ_ON_OP, 1'b0, 7'h00, 9'h000);
        check({31'h0, IRQ_ENABLE}, 32'h0000_0001);
        rdr(exec_pkg::OFF_STATUS, rd);
        check(rd, 32'h0000_0001);
        exec(exec_pkg::IRQ_OFF_OP, 1'b0, 7'h00, 9'h000);
        check({31'h0, IRQ_ENABLE}, 32'h0000_0000);
        rdr(exec_pkg::OFF_PROGRAM_COUNTER, rd);
        check(rd, 32'h0000_0002);
        // buffer bit 0 set on purpose: only bits 2:1 may reach the pc
        wr(exec_pkg::OFF_PC_HIGH_BUFFER, 32'h0000_0005);
        exec(exec_pkg::PAGED_JUMP_OP, 1'b0, 7'h00, 9'h1A5);
        rdr(exec_pkg::OFF_PROGRAM_COUNTER, rd);
        check(rd, 32'h0000_05A5);
        wr(exec_pkg::OFF_TABLE_HIGH_POINTER, 32'h0000_0002);
        wr(exec_pkg::OFF_ACCUMULATOR, 32'h0000_0034);
        exec(exec_pkg::COMPUTED_JUMP_OP, 1'b0, 7'h00, 9'h000);
        rdr(exec_pkg::OFF_PROGRAM_COUNTER, rd);
        check(rd, 32'h0000_0234);
        // a write on an unused byte lane must leave the accumulator as it was
        wb(1'b1, exec_pkg::OFF_ACCUMULATOR, 32'h0000_5A77, 4'h2, rd);
        rdr(exec_pkg::OFF_ACCUMULATOR, rd);
        check(rd, 32'h0000_0034);
        // increment with wrap into the register, then into the accumulator
        wr(exec_pkg::OFF_REG_SELECT, 32'h0000_007F);
        wr(exec_pkg::OFF_REG_DATA, 32'h0000_00FF);
        exec(exec_pkg::INCREMENT_OP, 1'b1, 7'h7F, 9'h000);
        rdr(exec_pkg::OFF_REG_DATA, rd);
        check(rd, 32'h0000_0000);
        rdr(exec_pkg::OFF_STATUS, rd);
        check({31'h0, rd[exec_pkg::ST_ZERO_BIT]}, 32'h0000_0001);
        wr(exec_pkg::OFF_REG_DATA, 32'h0000_0041);
        exec(exec_pkg::INCREMENT_OP, 1'b0, 7'h7F, 9'h000);
        rdr(exec_pkg::OFF_ACCUMULATOR, rd);
        check(rd, 32'h0000_0042);
        rdr(exec_pkg::OFF_REG_DATA, rd);
        check(rd, 32'h0000_0041);
        rdr(exec_pkg::OFF_STATUS, rd);
        check({31'h0, rd[exec_pkg::ST_ZERO_BIT]}, 32'h0000_0000);
        // increment-skip: zero result skips one slot, non-zero does not
        wr(exec_pkg::OFF_REG_SELECT, 32'h0000_0007);
        wr(exec_pkg::OFF_REG_DATA, 32'h0000_00FF);
        rdr(exec_pkg::OFF_PROGRAM_COUNTER, pc0);
        exec(exec_pkg::INCREMENT_SKIP_ZERO_OP, 1'b1, 7'h07, 9'h000);
        rdr(exec_pkg::OFF_PROGRAM_COUNTER, rd);
        check(rd, pc0 + 32'h0000_0002);
        rdr(exec_pkg::OFF_REG_DATA, rd);
        check(rd, 32'h0000_0000);
        wr(exec_pkg::OFF_REG_DATA, 32'h0000_0010);
        rdr(exec_pkg::OFF_PROGRAM_COUNTER, pc0);
        exec(exec_pkg::INCREMENT_SKIP_ZERO_OP, 1'b0, 7'h07, 9'h000);
        rdr(exec_pkg::OFF_PROGRAM_COUNTER, rd);
        check(rd, pc0 + 32'h0000_0001);
        rdr(exec_pkg::OFF_ACCUMULATOR, rd);
        check(rd, 32'h0000_0011);
        rdr(exec_pkg::OFF_REG_DATA, rd);
        check(rd, 32'h0000_0010);
        // trap from a known pc, with zero and carry preset to catch side effects
        wr(exec_pkg::OFF_PROGRAM_COUNTER, 32'h0000_0123);
        wr(exec_pkg::OFF_STATUS, 32'h0000_0006);
        exec(exec_pkg::TRAP_OP, 1'b0, 7'h00, 9'h000);
        rdr(exec_pkg::OFF_STACK_TOP, rd);
        check(rd, 32'h0000_0124);
        rdr(exec_pkg::OFF_PROGRAM_COUNTER, rd);
        check(rd, 32'h0000_0001);
        rdr(exec_pkg::OFF_STATUS, rd);
        check(rd & 32'h0000_0706, 32'h0000_0106);
        exec(exec_pkg::IRQ_ON_OP, 1'b0, 7'h00, 9'h000);
        exec(exec_pkg::PAGED_JUMP_OP, 1'b0, 7'h00, 9'h0FF);
        exec(exec_pkg::COMPUTED_JUMP_OP, 1'b0, 7'h00, 9'h000);
        exec(exec_pkg::IRQ_OFF_OP, 1'b0, 7'h00, 9'h000);
        rdr(exec_pkg::OFF_STATUS, rd);
        check(rd & 32'h0000_0007, 32'h0000_0006);
        // the spare code runs as a one-cycle step of the pc
        rdr(exec_pkg::OFF_PROGRAM_COUNTER, pc0);
        exec(exec_pkg::SPARE_OP, 1'b0, 7'h00, 9'h000);
        rdr(exec_pkg::OFF_PROGRAM_COUNTER, rd);
        check(rd, pc0 + 32'h0000_0001);
        end_sim();
    end
endmodule // test_exec_unit
`default_nettype wire
